// file: verilog/frame_seq_pkg.sv
package frame_seq_pkg;
  // register byte offsets (word aligned)
  localparam logic [7:0] OFS_FRAME_LINES = 8'h00;
  localparam logic [7:0] OFS_LINE_CLKS = 8'h04;
  localparam logic [7:0] OFS_EXTRA_DELAY = 8'h08;
  localparam logic [7:0] OFS_CONTROL = 8'h0C;
  localparam logic [7:0] OFS_INTEG = 8'h10;
  localparam logic [7:0] OFS_GAIN = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  // control field positions
  localparam int CTL_EMBED_BIT = 0;
  localparam int CTL_GPI_BIT = 1;
  localparam int CTL_TRIG_BIT = 2;
  localparam int CTL_PROTO_LSB = 4;
  localparam int CTL_DARK_LSB = 8;
  // reset values
  localparam logic [15:0] RST_FRAME_LINES = 16'h0020;
  localparam logic [15:0] RST_LINE_CLKS = 16'h0040;
  localparam logic [15:0] RST_EXTRA_DELAY = 16'h0000;
  localparam logic [3:0] RST_DARK = 4'h8;
  localparam logic [15:0] RST_INTEG = 16'h0010;
  localparam logic [15:0] RST_GAIN = 16'h0000;
  // blank rows besides dark rows: two embedded/blank plus two blank
  localparam logic [15:0] VB_EXTRA_ROWS = 16'h0004;
  localparam logic [15:0] EMBED_ROWS = 16'h0002;
  // inactive trigger window ends this many clocks before frame end
  localparam logic [31:0] TRIG_GUARD_CLKS = 32'h0000_0010;
  // protocols
  typedef enum logic [1:0] {
    PROTO_STREAM_END = 2'b00,
    PROTO_STREAM = 2'b01,
    PROTO_PACKET = 2'b10,
    PROTO_CSI2 = 2'b11
  } proto_e;
  // markers
  localparam logic [7:0] MK_NONE = 8'h00;
  localparam logic [7:0] MK_BLANK_ROW = 8'h01;
  localparam logic [7:0] MK_FRAME_START = 8'h02;
  localparam logic [7:0] MK_ACTIVE = 8'h03;
  localparam logic [7:0] MK_LINE_END = 8'h04;
  localparam logic [7:0] MK_FRAME_END = 8'h05;
  localparam logic [7:0] MK_EMBED = 8'h06;
endpackage : frame_seq_pkg

// file: verilog/marker_select.sv
`timescale 1ns/1ns
// chooses the marker code for a row event under the selected protocol
module marker_select (
  input wire logic [1:0] proto,
  input wire logic row_start,
  input wire logic row_end,
  input wire logic first_row,
  input wire logic last_row,
  input wire logic blank_row,
  input wire logic embed_row,
  output logic [7:0] code
);
  wire logic has_blank_mk;
  wire logic has_end_mk;
  wire logic [7:0] start_code;
  wire logic [7:0] end_code;
  // plain streaming lacks end markers; packet and csi-2 lack blank marker
  assign has_blank_mk = (proto == frame_seq_pkg::PROTO_STREAM_END) ||
                        (proto == frame_seq_pkg::PROTO_STREAM); // R15
  assign has_end_mk = (proto != frame_seq_pkg::PROTO_STREAM); // R15
  assign start_code = first_row ?
      ((proto == frame_seq_pkg::PROTO_STREAM) ? frame_seq_pkg::MK_BLANK_ROW
                                               : frame_seq_pkg::MK_FRAME_START) :
      embed_row ? frame_seq_pkg::MK_EMBED :
      blank_row ? (has_blank_mk ? frame_seq_pkg::MK_BLANK_ROW : frame_seq_pkg::MK_NONE) :
      frame_seq_pkg::MK_ACTIVE; // R15
  assign end_code = !has_end_mk ? frame_seq_pkg::MK_NONE :
      last_row ? frame_seq_pkg::MK_FRAME_END : frame_seq_pkg::MK_LINE_END;
  assign code = row_start ? start_code : (row_end ? end_code : frame_seq_pkg::MK_NONE);
endmodule : marker_select

// file: verilog/frame_timing_trigger_sequencer.sv
// Design decisions made here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
// Contract
// R01: rows-per-frame counts all row periods
// R02: vertical blanking is dark rows plus four
// R03: embed bit picks embedded or blank rows
// R04: embedded rows carry csi-2 style frame data
// R05: trigger mode needs both enable bits
// R06: active trigger mode starts frame on rising edge
// R07: inactive for frame time minus 16 clocks
// R08: edges while inactive are ignored
// R09: pointers halt while waiting for edge
// R10: free run starts after extra delay
// R11: controller keeps wait under 32 clocks
// R12: controller sets frame shorter than pulse period
// R13: controller keeps integration within pulse period
// R14: frame begins with blanking rows then active
// R15: markers chosen per output protocol
// R16: writes in frame n take effect n+2
// R17: frame period rows times clocks plus delay
// R18: pixel and row counters decide row types
module frame_timing_trigger_sequencer (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic vertical_drive_trigger,
  output logic frame_valid_out,
  output logic line_valid_out,
  output logic [7:0] sync_marker,
  output logic read_pointer_step,
  output logic shutter_pointer_step,
  output logic [15:0] integ_active,
  output logic [15:0] gain_active
);
  typedef enum logic [1:0] {
    ST_ROWS = 2'b00,
    ST_DELAY = 2'b01,
    ST_WAIT = 2'b10
  } seq_e;

  ////////////////////////////////////////////////////////////////////////////
  // software-side registers
  logic [15:0] frame_lines, line_clks, extra_delay, integ_w, gain_w;
  logic [15:0] ctl_w;
  // frame-boundary staged copies
  logic [15:0] frame_lines_s1, line_clks_s1, extra_delay_s1, integ_s1, gain_s1, ctl_s1;
  logic [15:0] frame_lines_a, line_clks_a, extra_delay_a, ctl_a;
  logic aw_held, w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : merge16

  wire logic do_write = aw_held && w_held && !s_axi_bvalid;
  wire logic wr_hit = (aw_addr <= frame_seq_pkg::OFS_STATUS) && (aw_addr[1:0] == 2'b00);
  wire logic rd_hit = (s_axi_araddr <= frame_seq_pkg::OFS_STATUS) &&
                      (s_axi_araddr[1:0] == 2'b00);

  // write address and data latch independently
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ready registers: accept only when the holding slot is free
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
    end
  end

  // register stores
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      frame_lines <= frame_seq_pkg::RST_FRAME_LINES;
      line_clks <= frame_seq_pkg::RST_LINE_CLKS;
      extra_delay <= frame_seq_pkg::RST_EXTRA_DELAY;
      ctl_w <= {4'h0, frame_seq_pkg::RST_DARK, 8'h01};
      integ_w <= frame_seq_pkg::RST_INTEG;
      gain_w <= frame_seq_pkg::RST_GAIN;
    end else if (do_write) begin
      case (aw_addr)
        frame_seq_pkg::OFS_FRAME_LINES: frame_lines <= merge16(frame_lines, w_data, w_strb);
        frame_seq_pkg::OFS_LINE_CLKS: line_clks <= merge16(line_clks, w_data, w_strb);
        frame_seq_pkg::OFS_EXTRA_DELAY: extra_delay <= merge16(extra_delay, w_data, w_strb);
        frame_seq_pkg::OFS_CONTROL: ctl_w <= merge16(ctl_w, w_data, w_strb);
        frame_seq_pkg::OFS_INTEG: integ_w <= merge16(integ_w, w_data, w_strb);
        frame_seq_pkg::OFS_GAIN: gain_w <= merge16(gain_w, w_data, w_strb);
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  seq_e state;
  logic [15:0] pix_cnt, row_cnt, dly_cnt;
  logic [31:0] frame_clk_cnt;
  logic trig_armed, vd_q;
  logic [15:0] frame_count;

  wire logic trig_mode = ctl_a[frame_seq_pkg::CTL_GPI_BIT] &&
                         ctl_a[frame_seq_pkg::CTL_TRIG_BIT]; // R05
  wire logic [15:0] dark_rows = {12'h000, ctl_a[frame_seq_pkg::CTL_DARK_LSB +: 4]}; // R02
  wire logic [15:0] vb_rows = dark_rows + frame_seq_pkg::VB_EXTRA_ROWS; // R02
  // minimum blanking leads the frame: two blank, dark, two embedded/blank rows
  wire logic [15:0] embed_first = vb_rows - frame_seq_pkg::EMBED_ROWS; // R14 R18
  wire logic [15:0] active_first = vb_rows; // R02 R14
  wire logic row_last_pix = (pix_cnt == line_clks_a - 16'h0001);
  wire logic frame_last_row = (row_cnt == frame_lines_a - 16'h0001); // R01
  wire logic frame_end = (state == ST_ROWS) && row_last_pix && frame_last_row;
  wire logic is_embed = (row_cnt >= embed_first) && (row_cnt < active_first) &&
                        ctl_a[frame_seq_pkg::CTL_EMBED_BIT]; // R03 R04
  wire logic is_active = (row_cnt >= active_first);
  wire logic vd_rise = vertical_drive_trigger && !vd_q;
  // frame time = lines*clks + delay; window closes 16 clocks earlier
  wire logic [31:0] frame_time = line_clks_a * frame_lines_a + {16'h0000, extra_delay_a}; // R17
  wire logic guard_done = (frame_clk_cnt + frame_seq_pkg::TRIG_GUARD_CLKS >= frame_time); // R07
  wire logic accept_vd = (state == ST_WAIT) && trig_armed && vd_rise; // R06 R08
  // delay state lasts extra_delay clocks, at least one
  wire logic delay_done = (dly_cnt + 16'h0001 >= extra_delay_a); // R17
  wire logic new_frame = accept_vd || ((state == ST_DELAY) && delay_done && !trig_mode); // R10
  wire logic [7:0] mk_code;

  marker_select u_marker (
    .proto(ctl_a[frame_seq_pkg::CTL_PROTO_LSB +: 2]),
    .row_start((state == ST_ROWS) && (pix_cnt == 16'h0000)),
    .row_end((state == ST_ROWS) && row_last_pix),
    .first_row(row_cnt == 16'h0000),
    .last_row(frame_last_row),
    .blank_row(!is_active && !is_embed),
    .embed_row(is_embed),
    .code(mk_code)
  );

  // row and pixel counters
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_ROWS;
      pix_cnt <= 16'h0000;
      row_cnt <= 16'h0000;
      dly_cnt <= 16'h0000;
    end else begin
      case (state)
        ST_ROWS: begin
          pix_cnt <= row_last_pix ? 16'h0000 : pix_cnt + 16'h0001; // R18
          if (row_last_pix) row_cnt <= frame_last_row ? 16'h0000 : row_cnt + 16'h0001;
          dly_cnt <= 16'h0000;
          if (frame_end) state <= ST_DELAY;
        end
        ST_DELAY: begin
          dly_cnt <= dly_cnt + 16'h0001;
          if (delay_done) state <= trig_mode ? ST_WAIT : ST_ROWS; // R10
        end
        ST_WAIT: begin
          if (accept_vd) state <= ST_ROWS; // R09
        end
        default: state <= ST_ROWS;
      endcase
    end
  end

  // trigger window: disarmed on accept, rearmed near frame end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      trig_armed <= 1'b1;
      frame_clk_cnt <= 32'h0000_0000;
      vd_q <= 1'b0;
    end else begin
      vd_q <= vertical_drive_trigger;
      frame_clk_cnt <= new_frame ? 32'h0000_0000 : frame_clk_cnt + 32'h0000_0001;
      if (accept_vd) trig_armed <= 1'b0; // R07
      else if (!trig_armed && guard_done) trig_armed <= 1'b1; // R07 R08
    end
  end

  // two-stage frame-boundary update of written values
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      frame_lines_s1 <= frame_seq_pkg::RST_FRAME_LINES;
      line_clks_s1 <= frame_seq_pkg::RST_LINE_CLKS;
      extra_delay_s1 <= frame_seq_pkg::RST_EXTRA_DELAY;
      ctl_s1 <= {4'h0, frame_seq_pkg::RST_DARK, 8'h01};
      integ_s1 <= frame_seq_pkg::RST_INTEG;
      gain_s1 <= frame_seq_pkg::RST_GAIN;
      frame_lines_a <= frame_seq_pkg::RST_FRAME_LINES;
      line_clks_a <= frame_seq_pkg::RST_LINE_CLKS;
      extra_delay_a <= frame_seq_pkg::RST_EXTRA_DELAY;
      ctl_a <= {4'h0, frame_seq_pkg::RST_DARK, 8'h01};
      integ_active <= frame_seq_pkg::RST_INTEG;
      gain_active <= frame_seq_pkg::RST_GAIN;
    end else if (frame_end) begin
      frame_lines_s1 <= frame_lines; // R16
      line_clks_s1 <= line_clks;
      extra_delay_s1 <= extra_delay;
      ctl_s1 <= ctl_w;
      integ_s1 <= integ_w;
      gain_s1 <= gain_w;
      frame_lines_a <= frame_lines_s1; // R16
      line_clks_a <= line_clks_s1;
      extra_delay_a <= extra_delay_s1;
      ctl_a <= ctl_s1;
      integ_active <= integ_s1;
      gain_active <= gain_s1;
    end
  end

  // outputs registered
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      frame_valid_out <= 1'b0;
      line_valid_out <= 1'b0;
      sync_marker <= 8'h00;
      read_pointer_step <= 1'b0;
      shutter_pointer_step <= 1'b0;
      frame_count <= 16'h0000;
    end else begin
      frame_valid_out <= (state == ST_ROWS) && is_active;
      line_valid_out <= (state == ST_ROWS) && is_active && !row_last_pix; // R18
      sync_marker <= mk_code; // R15
      read_pointer_step <= (state == ST_ROWS) && row_last_pix; // R09
      shutter_pointer_step <= (state != ST_WAIT) && row_last_pix; // R09
      if (frame_end) frame_count <= frame_count + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read channel
  wire logic [31:0] rd_mux =
      (s_axi_araddr == frame_seq_pkg::OFS_FRAME_LINES) ? {16'h0000, frame_lines} :
      (s_axi_araddr == frame_seq_pkg::OFS_LINE_CLKS) ? {16'h0000, line_clks} :
      (s_axi_araddr == frame_seq_pkg::OFS_EXTRA_DELAY) ? {16'h0000, extra_delay} :
      (s_axi_araddr == frame_seq_pkg::OFS_CONTROL) ? {16'h0000, ctl_w} :
      (s_axi_araddr == frame_seq_pkg::OFS_INTEG) ? {16'h0000, integ_w} :
      (s_axi_araddr == frame_seq_pkg::OFS_GAIN) ? {16'h0000, gain_w} :
      (s_axi_araddr == frame_seq_pkg::OFS_STATUS) ?
        {frame_count, 12'h000, trig_armed, trig_mode, state} : 32'h0000_0000;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_hit ? rd_mux : 32'h0000_0000;
        s_axi_rresp <= rd_hit ? 2'b00 : 2'b10;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  AST_TRIG_NEEDS_BOTH: assert property (@(posedge clk) disable iff (!resetn)
    (state == ST_WAIT) |-> (ctl_a[1] && ctl_a[2])) else $error("wait without trigger mode"); // R05
  AST_VD_STARTS: assert property (@(posedge clk) disable iff (!resetn)
    accept_vd |=> (state == ST_ROWS) && (row_cnt == 16'h0000)) else $error("vd not started"); // R06
  AST_DISARM: assert property (@(posedge clk) disable iff (!resetn)
    accept_vd |=> !trig_armed) else $error("trigger not disarmed"); // R07
  AST_IGNORE: assert property (@(posedge clk) disable iff (!resetn)
    (!trig_armed && vd_rise && trig_mode) |=> (frame_clk_cnt != 32'h0000_0000))
    else $error("edge accepted while inactive"); // R08
  AST_HALT: assert property (@(posedge clk) disable iff (!resetn)
    (state == ST_WAIT) |=> !read_pointer_step && !shutter_pointer_step) else $error("ptr moved"); // R09
  AST_FREE_RUN: assert property (@(posedge clk) disable iff (!resetn)
    (state == ST_DELAY && delay_done && !trig_mode) |=> state == ST_ROWS) else $error("no rerun"); // R10
  AST_ROW_WRAP: assert property (@(posedge clk) disable iff (!resetn)
    frame_end |=> row_cnt == 16'h0000 && state == ST_DELAY) else $error("frame wrap wrong"); // R01
  AST_STAGED: assert property (@(posedge clk) disable iff (!resetn)
    frame_end |=> integ_active == $past(integ_s1)) else $error("staging wrong"); // R16
  COV_FRAME: cover property (@(posedge clk) frame_end);
  COV_TRIG: cover property (@(posedge clk) accept_vd);
  COV_IGNORED: cover property (@(posedge clk) !trig_armed && vd_rise);
endmodule : frame_timing_trigger_sequencer

// file: verif/vd_source.sv
`timescale 1ns/1ns
// controller model: periodic vertical drive pulses, optional stray pulse
module vd_source (
  input wire logic clk,
  input wire logic resetn,
  input wire logic enable,
  input wire logic [15:0] period,
  input wire logic [15:0] early,
  output logic vd
);
  logic [15:0] count;
  logic main_hit;
  logic early_hit;
  ////////////////////////////////////////////////////////////////////////////////
  // pulse decode: main pulse opens each period, the stray one only on request
  assign main_hit = enable && (count < 16'h0004);
  assign early_hit = enable && (early != 16'h0000) && (count >= early) &&
                     (count < early + 16'h0004);
  assign vd = main_hit | early_hit;
  // period counter: bench picks a period a little above the frame time
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count <= 16'h0000;
    end else if (!enable || count == period - 16'h0001) begin
      count <= 16'h0000;
    end else begin
      count <= count + 16'h0001;
    end
  end
endmodule : vd_source

// file: verif/tb_frame_timing_trigger_sequencer.sv
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin fail_count++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module tb_frame_timing_trigger_sequencer;
  logic clk, resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr, sync_marker;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic frame_valid_out, line_valid_out, read_pointer_step, shutter_pointer_step;
  logic [15:0] integ_active, gain_active, old, val, vd_period, vd_early;
  logic vertical_drive_trigger, vd_en;
  logic [7:0] ofs [6];
  logic [31:0] rst [6];
  int fail_count = 0, comparisons = 0, cyc, steps, shut, lvr;
  int mk [8];
  ////////////////////////////////////////////////////////////////////////////////
  // clock, design and controller model
  always #2 clk = ~clk;
  frame_timing_trigger_sequencer dut (.clk, .resetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .vertical_drive_trigger,
    .frame_valid_out, .line_valid_out, .sync_marker, .read_pointer_step,
    .shutter_pointer_step, .integ_active, .gain_active);
  vd_source partner (.clk, .resetn, .enable(vd_en), .period(vd_period), .early(vd_early),
    .vd(vertical_drive_trigger));
  ////////////////////////////////////////////////////////////////////////////////
  // control word builder
  function automatic logic [31:0] ctl(input logic e, g, t, input logic [1:0] p,
                                      input logic [3:0] d);
    ctl = 32'h0000_0000;
    ctl[frame_seq_pkg::CTL_EMBED_BIT] = e;
    ctl[frame_seq_pkg::CTL_GPI_BIT] = g;
    ctl[frame_seq_pkg::CTL_TRIG_BIT] = t;
    ctl[frame_seq_pkg::CTL_PROTO_LSB +: 2] = p;
    ctl[frame_seq_pkg::CTL_DARK_LSB +: 4] = d;
  endfunction : ctl
  // bus write: ready sampled mid-cycle, released after the taking edge
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(negedge clk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tb = s_axi_bvalid;
      rsp = s_axi_bresp;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) begin
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask : axw
  // bus read
  task automatic axr(input logic [7:0] a);
    logic ta, tr;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(negedge clk);
      ta = s_axi_arvalid & s_axi_arready;
      tr = s_axi_rvalid;
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge clk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tr) begin
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask : axr
  // wait for frame valid to turn to level v
  task automatic wait_fv(input logic v);
    while (frame_valid_out === v) @(negedge clk);
    while (frame_valid_out !== v) @(negedge clk);
  endtask : wait_fv
  // one whole frame window, between two frame valid rises
  task automatic frame_stats();
    logic prev, prev_lv;
    wait_fv(1'b1);
    prev = 1'b0;
    prev_lv = 1'b0;
    cyc = 0;
    steps = 0;
    shut = 0;
    lvr = 0;
    mk = '{default: 0};
    // samples one whole period, from the rise up to the clock before the next
    forever begin
      steps += int'(read_pointer_step);
      shut += int'(shutter_pointer_step);
      mk[sync_marker[2:0]]++;
      if (line_valid_out && !prev_lv) lvr++;
      prev_lv = line_valid_out;
      prev = frame_valid_out;
      @(negedge clk);
      cyc++;
      if (frame_valid_out && !prev) break;
    end
  endtask : frame_stats
  // settings land two frame ends after the write
  task automatic settle();
    repeat (3) frame_stats();
  endtask : settle
  task automatic give_verdict();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict
  ////////////////////////////////////////////////////////////////////////////////
  // watchdog
  initial begin
    repeat (90000) @(posedge clk);
    fail_count++;
    give_verdict();
  end
  // main sequence
  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
    s_axi_wstrb = 4'hF;
    {vd_en, vd_period, vd_early} = 33'h0;
    ofs = '{frame_seq_pkg::OFS_FRAME_LINES, frame_seq_pkg::OFS_LINE_CLKS,
      frame_seq_pkg::OFS_EXTRA_DELAY, frame_seq_pkg::OFS_CONTROL, frame_seq_pkg::OFS_INTEG,
      frame_seq_pkg::OFS_GAIN};
    rst = '{32'h0000_0020, 32'h0000_0040, 32'h0000_0000, ctl(1'b1, 1'b0, 1'b0, 2'h0, 4'h8),
      32'h0000_0010, 32'h0000_0000};
    void'($urandom(32'h67B5));
    repeat (8) @(posedge clk);
    `CHK("integ_rst", 16'h0010, integ_active)
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 6; i++) begin
      axr(ofs[i]);
      `CHK("reg_rst", rst[i], rd)
    end
    axr(8'h1C);
    `CHK("unmapped_resp", 2'h2, rsp)
    `CHK("unmapped_data", 32'h0, rd)
    axr(8'h02);
    `CHK("unaligned_resp", 2'h2, rsp)
    axw(frame_seq_pkg::OFS_FRAME_LINES, 32'h0000_0010);
    axw(frame_seq_pkg::OFS_LINE_CLKS, 32'h0000_0020);
    axw(frame_seq_pkg::OFS_EXTRA_DELAY, 32'h0000_0008);
    settle();
    frame_stats();
    `CHK("frame_period", 16 * 32 + 8, cyc)
    `CHK("read_steps", 16, steps)
    `CHK("shutter_steps", 16, shut)
    for (int i = 0; i < 3; i++) begin
      axw(frame_seq_pkg::OFS_CONTROL, ctl(i != 1, 1'b0, 1'b0, 2'h0, 4'(8 >> i)));
      settle();
      frame_stats();
      `CHK("active_rows", 16 - (8 >> i) - 4, lvr)
      `CHK("active_marks", 16 - (8 >> i) - 4, mk[3])
      `CHK("embed_marks", (i != 1) ? 2 : 0, mk[6])
    end
    for (int p = 0; p < 4; p++) begin
      axw(frame_seq_pkg::OFS_CONTROL, ctl(1'b1, 1'b0, 1'b0, 2'(p), 4'h8));
      settle();
      frame_stats();
      `CHK("frame_start", p != 1, mk[2] != 0)
      `CHK("frame_end", p != 1, mk[5] != 0)
      `CHK("line_end", p != 1, mk[4] != 0)
      `CHK("blank_row", p < 2, mk[1] != 0)
      `CHK("active_line", 4, mk[3])
    end
    repeat (3) begin
      val = 16'($urandom);
      old = gain_active;
      wait_fv(1'b1);
      axw(frame_seq_pkg::OFS_GAIN, {16'h0000, val});
      wait_fv(1'b0);
      repeat (4) @(negedge clk);
      `CHK("gain_held", old, gain_active)
      wait_fv(1'b1);
      wait_fv(1'b0);
      repeat (4) @(negedge clk);
      `CHK("gain_new", val, gain_active)
    end
    for (int i = 0; i < 2; i++) begin
      axw(frame_seq_pkg::OFS_CONTROL, ctl(1'b1, i == 0, i == 1, 2'h0, 4'h8));
      settle();
      frame_stats();
      `CHK("one_bit_free_run", 520, cyc)
    end
    axw(frame_seq_pkg::OFS_CONTROL, ctl(1'b1, 1'b1, 1'b1, 2'h0, 4'h8));
    repeat (2000) @(negedge clk);
    steps = 0;
    repeat (1000) begin
      @(negedge clk);
      steps += int'(read_pointer_step) + int'(shutter_pointer_step);
    end
    `CHK("halted_steps", 0, steps)
    vd_period <= 16'(521 + $urandom % 30);
    vd_en <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      vd_early <= (i == 0) ? 16'h0000 : (i == 1) ? 16'd200 : 16'd500;
      repeat (2) frame_stats();
      frame_stats();
      `CHK("trig_period", int'(vd_period), cyc)
      `CHK("trig_steps", 16, steps)
    end
    give_verdict();
  end
endmodule : tb_frame_timing_trigger_sequencer
